// >>> rsch_pkg.sv
// Constants and types shared by the streaming read command handler.
package rsch_pkg;

    // ************************************************************
    // Task-file register selects
    // ************************************************************
    localparam logic [2:0] TF_FEAT = 3'h1; // Feature on write, error on read.
    localparam logic [2:0] TF_SCNT = 3'h2;
    localparam logic [2:0] TF_SNUM = 3'h3;
    localparam logic [2:0] TF_CYLL = 3'h4;
    localparam logic [2:0] TF_CYLH = 3'h5;
    localparam logic [2:0] TF_CMD  = 3'h7; // Command on write, status on read.

    // ************************************************************
    // Opcodes and field positions
    // ************************************************************
    localparam logic [7:0] OP_STREAM_DMA = 8'h2A;
    localparam logic [7:0] OP_STREAM_PIO = 8'h2B;
    localparam int FB_URG     = 7;
    localparam int FB_RC      = 6;
    localparam int FB_NS      = 5;
    localparam int FB_HSE     = 4;
    localparam int FB_SID_LSB = 0;
    localparam int SID_W      = 3;
    localparam int ST_BSY     = 7;
    localparam int ST_RDY     = 6;
    localparam int ST_SE      = 5;
    localparam int ST_DWE     = 4;
    localparam int ST_DRQ     = 3;
    localparam int ST_ERR     = 0;
    localparam int ER_COMPLETION_TIMEOUT_FLAG    = 0;
    // Error kinds that go to the log instead of the error byte.
    localparam logic [7:0] ER_LOG_MASK  = 8'hD4;
    localparam logic [7:0] ER_COMPLETION_TIMEOUT_FLAG_BIT  = 8'h01;

    // ************************************************************
    // Widths, reset values and timing
    // ************************************************************
    localparam int LBA_W   = 48;
    localparam int CNT_W   = 17;
    localparam int LIM_W   = 40;
    localparam logic [CNT_W-1:0] CNT_FULL = 17'h10000; // Zero count.
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_PAIR  = 16'h0000;
    localparam int US_NS       = 1000;
    localparam int CLK_NS      = 8;
    localparam int CYC_PER_US  = (US_NS + CLK_NS - 1) / CLK_NS;
    localparam int PRE_W       = 7;

    typedef enum logic [1:0] {
        RSCH_IDLE,
        RSCH_LOOKUP,
        RSCH_RUN
    } rsch_state_e;

endpackage : rsch_pkg

// >>> rsch_mem_if.sv
// Port bundle between the handler and its per-stream error address store.
`timescale 1ns/1ps
interface rsch_mem_if #(
    parameter int AW = 3,
    parameter int DW = 48
);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;

    modport owner (output wr_en, output wr_addr, output wr_data,
                   output rd_addr, input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data,
                   input rd_addr, output rd_data);
endinterface : rsch_mem_if

// >>> rsch_err_mem.sv
// Per-stream store of the last reported error address, registered read.
`timescale 1ns/1ps
module rsch_err_mem #(
    parameter int DEPTH = 8,
    parameter int AW    = 3,
    parameter int DW    = 48
) (
    input wire logic mclk,
    input wire logic srst,
    rsch_mem_if.store port_m
);
    import rsch_pkg::*;

    logic [DW-1:0] mem_q [DEPTH];
    logic [DW-1:0] rd_q;
    logic [DW-1:0] rd_d;

    // Read data is taken one edge after the address is presented.
    always_comb begin
        rd_d = mem_q[port_m.rd_addr];
    end

    // Entries clear at reset so an unused stream resumes at address zero.
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            rd_q <= '0;
        end else begin
            if (port_m.wr_en) begin
                mem_q[port_m.wr_addr] <= port_m.wr_data;
            end
            rd_q <= rd_d;
        end
    end

    assign port_m.rd_data = rd_q;

endmodule : rsch_err_mem

// >>> rsch_top.sv
// Streaming read command handler behind the task-file registers.
// Function
// - Urgent bit asks media for fastest service; the time limit still ends it.
// - Continuous mode ignores read errors, transfers all, ends with stream error.
// - Continuous mode with time limit expired stops and logs the time-out.
// - Without continuous mode an error ends the command with error status.
// - Handle-stream-error starts at the stream's last stored error address; a time-out without continuous mode stores none.
// - Stream number is feature bits 2:0 and selects per-stream state.
// - Time limit is previous feature byte times identify time unit microseconds.
// - Zero byte uses stream default; zero or unset default means no limit.
// - Time runs from command write until the completion interrupt.
// - Sector count is previous:current bytes; zero means 65536 sectors.
// - Address is 48 bits from three current and three previous bytes.
// - On error the failing address is returned; high-byte select picks half.
// - Error bit 0 flags that the completion time limit was exceeded.
// - Status bit 5 flags stream error; registers hold address and bad count.
// - Continuous-mode error kinds go to the log, not the error byte.
// - Status bit 4 flags a deferred write error from earlier writes.
// - Opcode 2Bh starts the programmed transfer variant.
// - In continuous mode all requested data is attempted within the time limit despite errors.
// - Opcode 2Ah starts the DMA variant with identical parameter handling.
`timescale 1ns/1ps
module rsch_top #(
    parameter int STREAMS = 8
) (
    input  wire logic                    mclk,
    input  wire logic                    srst,
    input  wire logic [2:0]              tf_addr,
    input  wire logic                    tf_wr,
    input  wire logic [7:0]              tf_wdata,
    input  wire logic                    tf_rd,
    input  wire logic                    hob,
    output logic      [7:0]              tf_rdata,
    output logic                         intrq,
    input  wire logic [31:0]             ident_time_unit,
    input  wire logic                    cfg_wr,
    input  wire logic [rsch_pkg::SID_W-1:0] cfg_stream,
    input  wire logic [7:0]              cfg_completion_time_limit,
    input  wire logic                    dwe_event,
    input  wire logic                    xfer_drq,
    input  wire logic                    sect_done,
    input  wire logic                    sect_err,
    input  wire logic [7:0]              sect_err_bits,
    output logic                         media_start,
    output logic                         media_stop,
    output logic [rsch_pkg::LBA_W-1:0]   media_lba,
    output logic [rsch_pkg::CNT_W-1:0]   media_count,
    output logic [rsch_pkg::SID_W-1:0]   media_stream,
    output logic                         media_urgent,
    output logic                         media_rc,
    output logic                         media_ns,
    output logic                         media_dma,
    output logic                         log_wr,
    output logic [rsch_pkg::SID_W-1:0]   log_stream,
    output logic [7:0]                   log_bits
);
    import rsch_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    rsch_state_e      st_q, st_d;
    logic [15:0]      feat_q, feat_d, scnt_q, scnt_d, snum_q, snum_d;
    logic [15:0]      cyll_q, cyll_d, cylh_q, cylh_d;
    logic [7:0]       err_q, err_d, rdata_q, rdata_d;
    logic             se_q, se_d, errst_q, errst_d, dwe_q, dwe_d;
    logic             irq_q, irq_d;
    logic [7:0]       dflt_q [STREAMS];
    logic [7:0]       dflt_d [STREAMS];
    logic [LBA_W-1:0] cur_q, cur_d, first_q, first_d;
    logic [CNT_W-1:0] left_q, left_d, bad_q, bad_d;
    logic             seen_q, seen_d, hse_q, hse_d;
    logic [LIM_W-1:0] lim_q, lim_d, us_q, us_d;
    logic             limon_q, limon_d;
    logic [PRE_W-1:0] pre_q, pre_d;
    logic             start_q, start_d, stop_q, stop_d, logw_q, logw_d;
    logic [7:0]       logb_q, logb_d;
    logic [SID_W-1:0] sid_q, sid_d;
    logic             urg_q, urg_d, rc_q, rc_d, ns_q, ns_d, dma_q, dma_d;
    logic             mwr;
    logic             cmd_hit, done_now, tmo_now;
    logic [7:0]       sel_completion_time_limit;
    logic [LBA_W-1:0] end_lba;
    logic [CNT_W-1:0] end_cnt;

    rsch_mem_if #(.AW(SID_W), .DW(LBA_W)) mem_b ();

    rsch_err_mem #(.DEPTH(STREAMS), .AW(SID_W), .DW(LBA_W)) u_mem (
        .mclk   (mclk),
        .srst   (srst),
        .port_m (mem_b)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************
    // One process owns every register so device results and host writes
    // to the same stacked bytes can never fight over a driver.
    always_comb begin
        st_d = st_q;  feat_d = feat_q;  scnt_d = scnt_q;  snum_d = snum_q;
        cyll_d = cyll_q;  cylh_d = cylh_q;  err_d = err_q;
        se_d = se_q;  errst_d = errst_q;  irq_d = irq_q;
        dflt_d = dflt_q;  cur_d = cur_q;  first_d = first_q;
        left_d = left_q;  bad_d = bad_q;  seen_d = seen_q;  hse_d = hse_q;
        lim_d = lim_q;  limon_d = limon_q;  us_d = us_q;  pre_d = pre_q;
        start_d = 1'b0;  stop_d = 1'b0;  logw_d = 1'b0;  logb_d = logb_q;
        sid_d = sid_q;  urg_d = urg_q;  rc_d = rc_q;  ns_d = ns_q;
        dma_d = dma_q;  mwr = 1'b0;  done_now = 1'b0;  tmo_now = 1'b0;
        end_lba = first_q;  end_cnt = bad_q;  rdata_d = rdata_q;
        cmd_hit = tf_wr && (tf_addr == TF_CMD) && (st_q == RSCH_IDLE);
        sel_completion_time_limit = (feat_q[15:8] != RST_BYTE) ? feat_q[15:8] : dflt_q[sid_q];

        if (cfg_wr) begin
            dflt_d[cfg_stream] = cfg_completion_time_limit;
        end
        if (dwe_event) begin
            dwe_d = 1'b1;
        end else if (cmd_hit) begin
            dwe_d = 1'b0;
        end else begin
            dwe_d = dwe_q;
        end

        if (tf_wr && st_q == RSCH_IDLE) begin
            case (tf_addr)
                TF_FEAT: feat_d = {feat_q[7:0], tf_wdata};
                TF_SCNT: scnt_d = {scnt_q[7:0], tf_wdata};
                TF_SNUM: snum_d = {snum_q[7:0], tf_wdata};
                TF_CYLL: cyll_d = {cyll_q[7:0], tf_wdata};
                TF_CYLH: cylh_d = {cylh_q[7:0], tf_wdata};
                default: ;
            endcase
        end

        if (cmd_hit && (tf_wdata == OP_STREAM_PIO
                        || tf_wdata == OP_STREAM_DMA)) begin
            st_d = RSCH_LOOKUP;
            sid_d = feat_q[FB_SID_LSB +: SID_W];
            urg_d = feat_q[FB_URG];
            rc_d = feat_q[FB_RC];
            ns_d = feat_q[FB_NS];
            hse_d = feat_q[FB_HSE];
            dma_d = (tf_wdata == OP_STREAM_DMA);
            cur_d = {cylh_q[15:8], cyll_q[15:8], snum_q[15:8],
                     cylh_q[7:0], cyll_q[7:0], snum_q[7:0]};
            left_d = (scnt_q == RST_PAIR) ? CNT_FULL : {1'b0, scnt_q};
            us_d = '0;
            pre_d = '0;
            err_d = RST_BYTE;
            se_d = 1'b0;
            errst_d = 1'b0;
            seen_d = 1'b0;
            bad_d = '0;
        end

        // Microsecond timer runs only while the command is open.
        if (st_q != RSCH_IDLE) begin
            if (pre_q == PRE_W'(CYC_PER_US - 1)) begin
                pre_d = '0;
                us_d = us_q + LIM_W'(1);
            end else begin
                pre_d = pre_q + PRE_W'(1);
            end
        end

        case (st_q)
            RSCH_IDLE: ;
            RSCH_LOOKUP: begin
                lim_d = LIM_W'(sel_completion_time_limit) * LIM_W'(ident_time_unit);
                limon_d = (lim_d != '0);
                if (hse_q) begin
                    cur_d = mem_b.rd_data;
                end
                start_d = 1'b1;
                st_d = RSCH_RUN;
            end
            RSCH_RUN: begin
                tmo_now = limon_q && (us_q >= lim_q);
                if (tmo_now) begin
                    done_now = 1'b1;
                    stop_d = 1'b1;
                    if (rc_q) begin
                        se_d = 1'b1;
                        logw_d = 1'b1;
                        logb_d = ER_COMPLETION_TIMEOUT_FLAG_BIT;
                        end_cnt = seen_q ? bad_q : left_q;
                        end_lba = seen_q ? first_q : cur_q;
                        mwr = 1'b1;
                    end else begin
                        errst_d = 1'b1;
                        err_d[ER_COMPLETION_TIMEOUT_FLAG] = 1'b1;
                        end_lba = cur_q;
                        end_cnt = left_q;
                    end
                end else if (sect_err && !rc_q) begin
                    done_now = 1'b1;
                    stop_d = 1'b1;
                    errst_d = 1'b1;
                    err_d = sect_err_bits;
                    end_lba = cur_q;
                    end_cnt = left_q;
                    mwr = 1'b1;
                end else begin
                    if (sect_err) begin
                        logw_d = 1'b1;
                        logb_d = sect_err_bits & ER_LOG_MASK;
                        if (!seen_q) begin
                            seen_d = 1'b1;
                            first_d = cur_q;
                            bad_d = CNT_W'(1);
                        end else if (cur_q == first_q + LBA_W'(bad_q)) begin
                            bad_d = bad_q + CNT_W'(1);
                        end
                    end
                    if (sect_done) begin
                        cur_d = cur_q + LBA_W'(1);
                        left_d = left_q - CNT_W'(1);
                        if (left_q == CNT_W'(1)) begin
                            done_now = 1'b1;
                            se_d = seen_d;
                            end_lba = first_d;
                            end_cnt = bad_d;
                            mwr = seen_d;
                        end
                    end
                end
                if (done_now) begin
                    st_d = RSCH_IDLE;
                    irq_d = 1'b1;
                    if (errst_d || se_d) begin
                        snum_d = {end_lba[31:24], end_lba[7:0]};
                        cyll_d = {end_lba[39:32], end_lba[15:8]};
                        cylh_d = {end_lba[47:40], end_lba[23:16]};
                    end
                    if (se_d) begin
                        scnt_d = end_cnt[15:0];
                    end
                end
            end
            default: st_d = RSCH_IDLE;
        endcase

        // Status read acknowledges the interrupt; a new end still wins.
        if (tf_rd) begin
            case (tf_addr)
                TF_FEAT: rdata_d = err_q;
                TF_SCNT: rdata_d = hob ? scnt_q[15:8] : scnt_q[7:0];
                TF_SNUM: rdata_d = hob ? snum_q[15:8] : snum_q[7:0];
                TF_CYLL: rdata_d = hob ? cyll_q[15:8] : cyll_q[7:0];
                TF_CYLH: rdata_d = hob ? cylh_q[15:8] : cylh_q[7:0];
                TF_CMD: begin
                    rdata_d = RST_BYTE;
                    rdata_d[ST_BSY] = (st_q != RSCH_IDLE);
                    rdata_d[ST_RDY] = 1'b1;
                    rdata_d[ST_SE] = se_q;
                    rdata_d[ST_DWE] = dwe_q;
                    rdata_d[ST_DRQ] = xfer_drq;
                    rdata_d[ST_ERR] = errst_q;
                    if (!done_now) begin
                        irq_d = 1'b0;
                    end
                end
                default: rdata_d = RST_BYTE;
            endcase
        end
    end

    // The stored address of the stream's last reported error.
    assign mem_b.rd_addr = feat_q[FB_SID_LSB +: SID_W];
    assign mem_b.wr_en = mwr;
    assign mem_b.wr_addr = sid_q;
    assign mem_b.wr_data = end_lba;

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_q <= RSCH_IDLE;  feat_q <= RST_PAIR;  scnt_q <= RST_PAIR;
            snum_q <= RST_PAIR;  cyll_q <= RST_PAIR;  cylh_q <= RST_PAIR;
            err_q <= RST_BYTE;  rdata_q <= RST_BYTE;  se_q <= 1'b0;
            errst_q <= 1'b0;  dwe_q <= 1'b0;  irq_q <= 1'b0;
            for (int i = 0; i < STREAMS; i++) begin
                dflt_q[i] <= RST_BYTE;
            end
            cur_q <= '0;  first_q <= '0;  left_q <= '0;  bad_q <= '0;
            seen_q <= 1'b0;  hse_q <= 1'b0;  lim_q <= '0;  limon_q <= 1'b0;
            us_q <= '0;  pre_q <= '0;  start_q <= 1'b0;  stop_q <= 1'b0;
            logw_q <= 1'b0;  logb_q <= RST_BYTE;  sid_q <= '0;
            urg_q <= 1'b0;  rc_q <= 1'b0;  ns_q <= 1'b0;  dma_q <= 1'b0;
        end else begin
            st_q <= st_d;  feat_q <= feat_d;  scnt_q <= scnt_d;
            snum_q <= snum_d;  cyll_q <= cyll_d;  cylh_q <= cylh_d;
            err_q <= err_d;  rdata_q <= rdata_d;  se_q <= se_d;
            errst_q <= errst_d;  dwe_q <= dwe_d;  irq_q <= irq_d;
            dflt_q <= dflt_d;
            cur_q <= cur_d;  first_q <= first_d;  left_q <= left_d;
            bad_q <= bad_d;  seen_q <= seen_d;  hse_q <= hse_d;
            lim_q <= lim_d;  limon_q <= limon_d;  us_q <= us_d;
            pre_q <= pre_d;  start_q <= start_d;  stop_q <= stop_d;
            logw_q <= logw_d;  logb_q <= logb_d;  sid_q <= sid_d;
            urg_q <= urg_d;  rc_q <= rc_d;  ns_q <= ns_d;  dma_q <= dma_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // urgent to media
    assign media_urgent = urg_q;
    assign tf_rdata     = rdata_q;
    assign intrq        = irq_q;
    assign media_start  = start_q;
    assign media_stop   = stop_q;
    assign media_lba    = cur_q;
    assign media_count  = left_q;
    assign media_stream = sid_q;
    assign media_rc     = rc_q;
    assign media_ns     = ns_q;
    assign media_dma    = dma_q;
    assign log_wr       = logw_q;
    assign log_stream   = sid_q;
    assign log_bits     = logb_q;

endmodule : rsch_top

// >>> rsch_props.sv
// Port checker of the streaming read command handler.
`timescale 1ns/1ps
module rsch_props
    import rsch_pkg::*;
(
    input wire logic             mclk,
    input wire logic             srst,
    input wire logic [2:0]       tf_addr,
    input wire logic             tf_wr,
    input wire logic [7:0]       tf_wdata,
    input wire logic             tf_rd,
    input wire logic             intrq,
    input wire logic             sect_done,
    input wire logic             sect_err,
    input wire logic             media_start,
    input wire logic             media_stop,
    input wire logic [LBA_W-1:0] media_lba,
    input wire logic [CNT_W-1:0] media_count,
    input wire logic             media_rc,
    input wire logic             media_dma,
    input wire logic             log_wr
);
    logic run_q;
    logic live;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // Live from the cycle after the start pulse until the end interrupt rises.
    assign live = run_q & ~intrq;
    always_ff @(posedge mclk) begin
        run_q <= srst ? 1'b0 : (media_start | live);
    end
    a_start_cause: assert property (media_start |-> $past(tf_wr, 2)
        && $past(tf_addr, 2) == TF_CMD) else $error("start without command");
    a_dma_flag: assert property (media_start |-> media_dma ==
        ($past(tf_wdata, 2) == OP_STREAM_DMA)) else $error("variant wrong");
    a_no_restart: assert property (live |-> !media_start)
        else $error("command started while busy");
    a_error_abort: assert property (live && sect_err && !media_rc
        |=> media_stop && intrq) else $error("error did not abort");
    a_cont_logs: assert property (live && sect_err && media_rc
        |=> log_wr && !media_stop) else $error("error not logged");
    a_sector_step: assert property (live && sect_done && !sect_err
        && media_count > 1 |=> media_lba == $past(media_lba) + 1
        && media_count == $past(media_count) - 1) else $error("no advance");
    a_last_ends: assert property (live && sect_done
        && media_count == 1 |=> intrq) else $error("last sector no end");
    a_irq_clear: assert property (intrq && tf_rd
        && tf_addr == TF_CMD |=> !intrq) else $error("interrupt not cleared");
endmodule : rsch_props
bind rsch_top rsch_props u_rsch_props (.mclk, .srst, .tf_addr, .tf_wr,
    .tf_wdata, .tf_rd, .intrq, .sect_done, .sect_err, .media_start,
    .media_stop, .media_lba, .media_count, .media_rc, .media_dma, .log_wr);

// >>> rsch_host.sv
// Host controller model that loads and reads the task-file registers.
`timescale 1ns/1ps
module rsch_host
    import rsch_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic [7:0] tf_rdata,
    output logic      [2:0] tf_addr  = 3'h0,
    output logic            tf_wr    = 1'b0,
    output logic      [7:0] tf_wdata = 8'h00,
    output logic            tf_rd    = 1'b0,
    output logic            hob      = 1'b0
);
    // Data turns to the inverse of the written byte once the strobe is gone.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        tf_addr  <= a;
        tf_wdata <= d;
        tf_wr    <= 1'b1;
        @(posedge mclk);
        tf_wr    <= 1'b0;
        tf_wdata <= ~d;
    endtask : wr
    // Read data lands on the edge that samples the strobe.
    task automatic rd(input logic [2:0] a, input logic h,
                      output logic [7:0] q);
        @(posedge mclk);
        tf_addr <= a;
        hob     <= h;
        tf_rd   <= 1'b1;
        @(posedge mclk);
        tf_rd   <= 1'b0;
        #1;
        q = tf_rdata;
    endtask : rd
    task automatic cmd(input logic [7:0] op, input logic [15:0] ft,
                       input logic [15:0] ct, input logic [47:0] l);
        logic [15:0] v [5];
        v = '{ft, ct, {l[31:24], l[7:0]}, {l[39:32], l[15:8]},
              {l[47:40], l[23:16]}};
        for (int k = 0; k < 5; k++) begin
            wr(3'(k + 1), v[k][15:8]);
            wr(3'(k + 1), v[k][7:0]);
        end
        wr(TF_CMD, op);
    endtask : cmd
endmodule : rsch_host

// >>> tb.sv
// Self-checking bench of the streaming read command handler.
`timescale 1ns/1ps
module tb;
    import rsch_pkg::*;
    logic        mclk = 1'b0, srst = 1'b1, cfg_wr = 1'b0, sect_err = 1'b0;
    logic        dwe_event = 1'b0, sect_done = 1'b0, tf_wr, tf_rd, hob;
    logic        intrq, media_start, media_stop, media_urgent, media_rc;
    logic        media_ns, media_dma, log_wr;
    logic [2:0]  tf_addr, media_stream, log_stream, cfg_stream = 3'h0;
    logic [7:0]  tf_wdata, tf_rdata, log_bits, q, cfg_completion_time_limit = 8'h00;
    logic [7:0]  sect_err_bits = 8'h00;
    logic [31:0] ident_time_unit = 32'h00000002, seed = 32'h0000000E;
    logic [47:0] media_lba, lba, a;
    logic [16:0] media_count;
    int          fails = 0, n_checks = 0, cyc = 0, t0;
    initial forever #4 mclk = ~mclk;
    rsch_top u_rsch_top (.mclk, .srst, .tf_addr, .tf_wr, .tf_wdata, .tf_rd,
        .hob, .tf_rdata, .intrq, .ident_time_unit, .cfg_wr, .cfg_stream,
        .cfg_completion_time_limit, .dwe_event, .xfer_drq(1'b0), .sect_done, .sect_err,
        .sect_err_bits, .media_start, .media_stop, .media_lba, .media_count,
        .media_stream, .media_urgent, .media_rc, .media_ns, .media_dma,
        .log_wr, .log_stream, .log_bits);
    rsch_host u_rsch_host (.mclk, .tf_rdata, .tf_addr, .tf_wr, .tf_wdata,
        .tf_rd, .hob);
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Bits 2:1 carry nothing for this command, so they are masked.
    task automatic st(input logic se, input logic err);
        u_rsch_host.rd(TF_CMD, 1'b0, q);
        chk(q & 8'hF9, {2'b01, se, 4'h0, err});
    endtask : st
    task automatic await(input logic irq, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge mclk);
            #1;
            if ((irq ? intrq : media_start) === 1'b1) break;
        end
    endtask : await
    task automatic sect(input logic e, input logic [7:0] b);
        @(posedge mclk);
        sect_done     <= 1'b1;
        sect_err      <= e;
        sect_err_bits <= b;
        @(posedge mclk);
        sect_done     <= 1'b0;
        sect_err      <= 1'b0;
        sect_err_bits <= ~b;
    endtask : sect
    task automatic rd_lba;
        for (int k = 0; k < 6; k++) begin
            u_rsch_host.rd(TF_SNUM + 3'(k % 3), k > 2, q);
            a[8*k +: 8] = q;
        end
    endtask : rd_lba
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    // A hung run is cut short well past the expected length.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            print_verdict();
        end
    end
    // Main sequence: random ordinary reads, error endings, time limits.
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            lba = {seed[15:0], xs(seed)};
            u_rsch_host.cmd(i[0] ? OP_STREAM_DMA : OP_STREAM_PIO,
                {8'h00, seed[7], 1'b0, seed[5], 2'b00, seed[2:0]},
                {14'h0000, seed[9:8]} + 16'h0001, lba);
            await(1'b0, 20);
            chk(media_start, 1'b1);
            chk(media_lba, lba);
            chk(media_count, {15'h0000, seed[9:8]} + 17'h00001);
            chk({media_stream, media_urgent}, {seed[2:0], seed[7]});
            chk(media_dma, i[0]);
            chk({media_ns, media_rc}, {seed[5], 1'b0});
            repeat (seed[9:8] + 1) sect(1'b0, 8'h00);
            await(1'b1, 20);
            st(1'b0, 1'b0);
        end
        $display("test random done");
        lba = 48'h123456789ABC;
        u_rsch_host.cmd(OP_STREAM_PIO, 16'h0002, 16'h0000, lba);
        await(1'b0, 20);
        chk(media_count, CNT_FULL);
        sect(1'b0, 8'h00);
        sect(1'b1, 8'h40);
        await(1'b1, 10);
        st(1'b0, 1'b1);
        u_rsch_host.rd(TF_FEAT, 1'b0, q);
        chk(q, 8'h40);
        rd_lba();
        chk(a, lba + 48'h1);
        lba = 48'h0A0B0C0D0E0F;
        u_rsch_host.cmd(OP_STREAM_DMA, 16'h0043, 16'h0003, lba);
        await(1'b0, 20);
        sect(1'b0, 8'h00);
        sect(1'b1, 8'h10);
        sect(1'b0, 8'h00);
        await(1'b1, 10);
        st(1'b1, 1'b0);
        u_rsch_host.rd(TF_FEAT, 1'b0, q);
        chk({log_stream, q}, 11'h300);
        u_rsch_host.rd(TF_SCNT, 1'b0, q);
        chk(q, 8'h01);
        rd_lba();
        chk(a, lba + 48'h1);
        u_rsch_host.cmd(OP_STREAM_PIO, 16'h0013, 16'h0001, 48'h0);
        await(1'b0, 20);
        chk(media_lba, lba + 48'h1);
        sect(1'b0, 8'h00);
        await(1'b1, 10);
        st(1'b0, 1'b0);
        $display("test error endings done");
        // Two microsecond limits: from the feature byte, then a default.
        for (int j = 0; j < 2; j++) begin
            @(posedge mclk);
            cfg_wr     <= j[0];
            cfg_stream <= 3'h6;
            cfg_completion_time_limit   <= 8'h01;
            @(posedge mclk);
            cfg_wr     <= 1'b0;
            u_rsch_host.cmd(j[0] ? OP_STREAM_DMA : OP_STREAM_PIO,
                j[0] ? 16'h0006 : 16'h0145, 16'h0004, lba);
            t0 = cyc;
            await(1'b1, 400);
            chk((cyc - t0) inside {[248:262]}, 1'b1);
            st(!j[0], j[0]);
            u_rsch_host.rd(TF_FEAT, 1'b0, q);
            chk(j[0] ? q : log_bits, 8'h01);
        end
        $display("test limits done");
        @(posedge mclk);
        dwe_event <= 1'b1;
        @(posedge mclk);
        dwe_event <= 1'b0;
        u_rsch_host.rd(TF_CMD, 1'b0, q);
        chk(q[4], 1'b1);
        $display("test deferred write done");
        print_verdict();
    end
endmodule : tb
